/* pkg/lct_regs.svh */
// register offsets, field positions, reset values and fixed codes of the loop code transmitter
`ifndef LCT_REGS_SVH
`define LCT_REGS_SVH
`define LCT_OFF_CTRL   8'h00
`define LCT_OFF_CMD    8'h04
`define LCT_OFF_STAT   8'h08
`define LCT_OFF_CHAN   8'h0c
`define LCT_OFF_ADDR   8'h10
`define LCT_PAGE_UP    2'b01
`define LCT_PAGE_DN    2'b10
`define LCT_F_MODE     0
`define LCT_F_FRAC     2
`define LCT_F_ESF      3
`define LCT_F_DDSALT   4
`define LCT_F_AUTO     5
`define LCT_F_SRC      6
`define LCT_F_SET      9
`define LCT_F_YEL      13
`define LCT_F_LIDLE    15
`define LCT_F_VOICE    16
`define LCT_F_UP       0
`define LCT_F_DN       1
`define LCT_F_INC      2
`define LCT_F_DEC      3
`define LCT_F_LBCLR    4
`define LCT_F_CH       8
`define LCT_F_ABCD     13
`define LCT_F_FMT      17
`define LCT_F_LEN      16
`define LCT_UP_RST     16'h0010
`define LCT_UP_LEN_RST 5'd5
`define LCT_DN_RST     16'h0004
`define LCT_DN_LEN_RST 5'd3
`define LCT_LEN_MIN    5'd3
`define LCT_LEN_MAX    5'd16
`define LCT_IDLE_RST   8'h7f
`define LCT_CH_RST     5'd1
`define LCT_CH_MAX     5'd24
`define LCT_ABCD_RST   4'h7
`define LCT_LLB_UP     16'hff70
`define LCT_LLB_DN     16'hff1c
`define LCT_PLB_UP     16'hff28
`define LCT_PLB_DN     16'hff4c
`define LCT_NET_UP     16'h0048
`define LCT_NET_DN     16'h0024
`endif

/* pkg/lct_pkg.sv */
// types of the loop code transmitter
package lct_pkg;
   typedef enum logic [1:0] {LCT_TERM = 2'b00, LCT_DI = 2'b01, LCT_MON = 2'b10, LCT_LLB = 2'b11} lct_mode_t;
   typedef enum logic [2:0] {
      LCT_SRC_PROG = 3'b000, LCT_SRC_V54 = 3'b001, LCT_SRC_LLB = 3'b010, LCT_SRC_PLB = 3'b011,
      LCT_SRC_NET = 3'b100, LCT_SRC_ARM = 3'b101, LCT_SRC_NEAR = 3'b110, LCT_SRC_DISARM = 3'b111
   } lct_src_t;
   typedef enum logic [1:0] {LCT_YEL_OFF = 2'b00, LCT_YEL_ON = 2'b01, LCT_YEL_AUTO = 2'b10} lct_yel_t;
   typedef enum logic [1:0] {LCT_LB_NONE = 2'b00, LCT_LB_LINE = 2'b01, LCT_LB_PAY = 2'b10,
                             LCT_LB_FRAC = 2'b11} lct_lb_t;
   typedef enum logic [1:0] {LCT_RX_LINE = 2'b00, LCT_RX_PAY = 2'b01, LCT_RX_V54 = 2'b10,
                             LCT_RX_OTHER = 2'b11} lct_rx_t;
   typedef enum logic [1:0] {LCT_FMT_D1D = 2'b00, LCT_FMT_D2 = 2'b01, LCT_FMT_D34 = 2'b10} lct_fmt_t;
   typedef enum logic {LCT_ST_IDLE = 1'b0, LCT_ST_SEND = 1'b1} lct_state_t;
endpackage

/* core/lct_loop_code_tx.sv */
// loop code transmitter with apb register file
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "lct_regs.svh"
module lct_loop_code_tx #(
   parameter int unsigned NSETS      = 10,
   parameter logic [15:0] V54_UP     = 16'h0001,
   parameter logic [15:0] V54_DN     = 16'h0002,
   parameter logic [15:0] ARM_CODE   = 16'h0003,
   parameter logic [15:0] NEAR_CODE  = 16'h0005,
   parameter logic [15:0] DISARM_CODE = 16'h0006
)(
   input  wire logic        CLK_I,
   input  wire logic        RSTN_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic [31:0]      PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic        BIT_REQ_I,
   input  wire logic [2:0]  BIT_POS_I,
   input  wire logic        CHAN_ACTIVE_I,
   input  wire logic        PAY_BIT_I,
   output logic             TX_BIT_O,
   input  wire logic        OPP_BIT_I,
   output logic             OPP_BIT_O,
   input  wire logic        DL_REQ_I,
   input  wire logic        DL_BIT_I,
   output logic             DL_BIT_O,
   input  wire logic        LOS_I,
   input  wire logic        RX_UP_I,
   input  wire logic        RX_DN_I,
   input  wire logic [1:0]  RX_KIND_I,
   output logic             YELLOW_O,
   output logic             LINE_IDLE_O,
   output logic [1:0]       LOOPBACK_O,
   output logic             VOICE_EN_O,
   output logic [4:0]       VOICE_CHAN_O,
   output logic [3:0]       SIG_ABCD_O,
   output logic [1:0]       CHAN_FMT_O,
   output logic [10:0]      REP_ADDR_O
);
   logic                 rst_s1_reg;
   logic                 rst_n;
   logic                 los_s1_reg;
   logic                 los_reg;
   lct_pkg::lct_mode_t   mode_reg;
   logic                 frac_reg;
   logic                 esf_reg;
   logic                 dds_alt_reg;
   logic                 auto_reg;
   lct_pkg::lct_src_t    src_reg;
   logic [3:0]           set_reg;
   lct_pkg::lct_yel_t    yel_reg;
   logic                 lidle_reg;
   logic                 voice_reg;
   logic                 cmd_up_reg;
   logic                 cmd_dn_reg;
   logic [7:0]           idle_reg;
   logic [4:0]           chan_reg;
   logic [3:0]           abcd_reg;
   lct_pkg::lct_fmt_t    fmt_reg;
   logic [10:0]          addr_reg;
   lct_pkg::lct_lb_t     lb_reg;
   lct_pkg::lct_lb_t     lb_next;
   lct_pkg::lct_state_t  state_reg;
   lct_pkg::lct_state_t  state_next;
   logic [3:0]           idx_reg;
   logic [15:0]          up_code_reg [NSETS];
   logic [4:0]           up_len_reg  [NSETS];
   logic [15:0]          dn_code_reg [NSETS];
   logic [4:0]           dn_len_reg  [NSETS];
   logic [31:0]          rdata_next;
   logic [15:0]          cur_code;
   logic [4:0]           cur_len;

   // address decode of the numbered code pages
   function automatic logic page_hit(input logic [7:0] a, input logic [1:0] page);
      page_hit = (a[7:6] == page) && ({28'h0, a[5:2]} < NSETS);
   endfunction

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rst_s1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n      <= rst_s1_reg;
      end
   end

   // loss of signal comes from the line side, so synchronise it
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         los_s1_reg <= 1'b0;
         los_reg    <= 1'b0;
      end else begin
         los_s1_reg <= LOS_I;
         los_reg    <= los_s1_reg;
      end
   end

   // apb decode; slave never waits, so each access takes exactly two cycles
   wire logic       acc    = PSEL_I & PENABLE_I;
   wire logic       wr     = acc & PWRITE_I;
   wire logic [3:0] widx   = PADDR_I[5:2];
   wire logic       up_hit = page_hit(PADDR_I, `LCT_PAGE_UP);
   wire logic       dn_hit = page_hit(PADDR_I, `LCT_PAGE_DN);
   wire logic       w_ctrl = wr && PADDR_I == `LCT_OFF_CTRL;
   wire logic       w_cmd  = wr && PADDR_I == `LCT_OFF_CMD;
   wire logic       w_chan = wr && PADDR_I == `LCT_OFF_CHAN;
   wire logic       w_addr = wr && PADDR_I == `LCT_OFF_ADDR;
   wire logic       hit    = up_hit | dn_hit | PADDR_I == `LCT_OFF_CTRL | PADDR_I == `LCT_OFF_CMD |
                             PADDR_I == `LCT_OFF_STAT | PADDR_I == `LCT_OFF_CHAN | PADDR_I == `LCT_OFF_ADDR;
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = acc & ~hit;

   // field values carried by a write
   wire logic [4:0] w_len    = PWDATA_I[`LCT_F_LEN +: 5];
   wire logic       len_ok   = w_len >= `LCT_LEN_MIN && w_len <= `LCT_LEN_MAX;
   wire logic [3:0] w_set    = PWDATA_I[`LCT_F_SET +: 4];
   wire logic [4:0] w_ch     = PWDATA_I[`LCT_F_CH +: 5];
   wire logic [1:0] w_yel    = PWDATA_I[`LCT_F_YEL +: 2];
   wire logic [1:0] w_fmt    = PWDATA_I[`LCT_F_FMT +: 2];
   wire logic [3:0] w_abcd   = PWDATA_I[`LCT_F_ABCD +: 4];
   wire logic       inc_cmd  = w_cmd & PWDATA_I[`LCT_F_INC];
   wire logic       dec_cmd  = w_cmd & PWDATA_I[`LCT_F_DEC];
   wire logic       lb_clr   = w_cmd & PWDATA_I[`LCT_F_LBCLR];

   // read data is captured in the setup cycle and held through the access cycle
   always_comb begin
      rdata_next = 32'h0;
      if (up_hit) begin
         rdata_next = {11'h0, up_len_reg[widx], up_code_reg[widx]};
      end else if (dn_hit) begin
         rdata_next = {11'h0, dn_len_reg[widx], dn_code_reg[widx]};
      end else begin
         case (PADDR_I)
            `LCT_OFF_CTRL: rdata_next = {15'h0, voice_reg, lidle_reg, yel_reg, set_reg, src_reg,
                                         auto_reg, dds_alt_reg, esf_reg, frac_reg, mode_reg};
            `LCT_OFF_CMD:  rdata_next = {30'h0, cmd_dn_reg, cmd_up_reg};
            `LCT_OFF_STAT: rdata_next = {28'h0, los_reg, lb_reg, state_reg == lct_pkg::LCT_ST_SEND};
            `LCT_OFF_CHAN: rdata_next = {13'h0, fmt_reg, abcd_reg, chan_reg, idle_reg};
            `LCT_OFF_ADDR: rdata_next = {21'h0, addr_reg};
            default:       rdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         PRDATA_O <= 32'h0;
      end else if (PSEL_I && !PENABLE_I) begin
         PRDATA_O <= rdata_next;
      end
   end

   // code set storage; a write with an illegal length is dropped whole
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NSETS; i++) begin
            up_code_reg[i] <= `LCT_UP_RST;
            up_len_reg[i]  <= `LCT_UP_LEN_RST;
            dn_code_reg[i] <= `LCT_DN_RST;
            dn_len_reg[i]  <= `LCT_DN_LEN_RST;
         end
      end else if (wr && len_ok) begin
         if (up_hit) begin
            up_code_reg[widx] <= PWDATA_I[15:0];
            up_len_reg[widx]  <= w_len;
         end
         if (dn_hit) begin
            dn_code_reg[widx] <= PWDATA_I[15:0];
            dn_len_reg[widx]  <= w_len;
         end
      end
   end

   // control register; illegal set numbers and yellow codes keep the old value
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg    <= lct_pkg::LCT_TERM;
         frac_reg    <= 1'b0;
         esf_reg     <= 1'b0;
         dds_alt_reg <= 1'b0;
         auto_reg    <= 1'b0;
         src_reg     <= lct_pkg::LCT_SRC_PROG;
         set_reg     <= 4'h0;
         yel_reg     <= lct_pkg::LCT_YEL_OFF;
         lidle_reg   <= 1'b0;
         voice_reg   <= 1'b0;
      end else if (w_ctrl) begin
         mode_reg    <= lct_pkg::lct_mode_t'(PWDATA_I[`LCT_F_MODE +: 2]);
         frac_reg    <= PWDATA_I[`LCT_F_FRAC];
         esf_reg     <= PWDATA_I[`LCT_F_ESF];
         dds_alt_reg <= PWDATA_I[`LCT_F_DDSALT];
         auto_reg    <= PWDATA_I[`LCT_F_AUTO];
         src_reg     <= lct_pkg::lct_src_t'(PWDATA_I[`LCT_F_SRC +: 3]);
         lidle_reg   <= PWDATA_I[`LCT_F_LIDLE];
         voice_reg   <= PWDATA_I[`LCT_F_VOICE];
         if ({28'h0, w_set} < NSETS) begin
            set_reg <= w_set;
         end
         if (w_yel != 2'b11) begin
            yel_reg <= lct_pkg::lct_yel_t'(w_yel);
         end
      end
   end

   // command levels and the repeater address; inc and dec together cancel
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         cmd_up_reg <= 1'b0;
         cmd_dn_reg <= 1'b0;
         addr_reg   <= 11'h0;
      end else begin
         if (w_cmd) begin
            cmd_up_reg <= PWDATA_I[`LCT_F_UP];
            cmd_dn_reg <= PWDATA_I[`LCT_F_DN];
         end
         if (w_addr) begin
            addr_reg <= PWDATA_I[10:0];
         end else if (inc_cmd && !dec_cmd) begin
            addr_reg <= addr_reg + 11'h1;
         end else if (dec_cmd && !inc_cmd) begin
            addr_reg <= addr_reg - 11'h1;
         end
      end
   end

   // channel register; c/d only under esf, format only under sf
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         idle_reg <= `LCT_IDLE_RST;
         chan_reg <= `LCT_CH_RST;
         abcd_reg <= `LCT_ABCD_RST;
         fmt_reg  <= lct_pkg::LCT_FMT_D34;
      end else if (w_chan) begin
         idle_reg <= PWDATA_I[7:0];
         if (w_ch >= 5'd1 && w_ch <= `LCT_CH_MAX) begin
            chan_reg <= w_ch;
         end
         abcd_reg[3:2] <= w_abcd[3:2];
         if (esf_reg) begin
            abcd_reg[1:0] <= w_abcd[1:0];
         end
         if (!esf_reg && w_fmt != 2'b11) begin
            fmt_reg <= lct_pkg::lct_fmt_t'(w_fmt);
         end
      end
   end

   // current code: programmable set, v.54, fixed link pairs, or span commands
   always_comb begin
      cur_len  = `LCT_LEN_MAX;
      cur_code = 16'h0;
      case (src_reg)
         lct_pkg::LCT_SRC_PROG: begin
            cur_code = cmd_up_reg ? up_code_reg[set_reg] : dn_code_reg[set_reg];
            cur_len  = cmd_up_reg ? up_len_reg[set_reg] : dn_len_reg[set_reg];
         end
         lct_pkg::LCT_SRC_V54:    cur_code = cmd_up_reg ? V54_UP : V54_DN;
         lct_pkg::LCT_SRC_LLB:    cur_code = cmd_up_reg ? `LCT_LLB_UP : `LCT_LLB_DN;
         lct_pkg::LCT_SRC_PLB:    cur_code = cmd_up_reg ? `LCT_PLB_UP : `LCT_PLB_DN;
         lct_pkg::LCT_SRC_NET:    cur_code = cmd_up_reg ? `LCT_NET_UP : `LCT_NET_DN;
         lct_pkg::LCT_SRC_ARM:    cur_code = ARM_CODE;
         lct_pkg::LCT_SRC_NEAR:   cur_code = NEAR_CODE;
         lct_pkg::LCT_SRC_DISARM: cur_code = DISARM_CODE;
         default:                 cur_code = 16'h0;
      endcase
   end

   // legality of sending: terminate only, v.54 fractional, link codes esf only
   wire logic is_link = src_reg == lct_pkg::LCT_SRC_LLB || src_reg == lct_pkg::LCT_SRC_PLB ||
                        src_reg == lct_pkg::LCT_SRC_NET;
   wire logic v54_ok  = src_reg != lct_pkg::LCT_SRC_V54 || (frac_reg && !dds_alt_reg);
   wire logic link_ok = !is_link || esf_reg;
   wire logic send_rq = (cmd_up_reg | cmd_dn_reg) && mode_reg == lct_pkg::LCT_TERM && v54_ok && link_ok;
   wire logic sending = state_reg == lct_pkg::LCT_ST_SEND;
   wire logic strobe  = is_link ? DL_REQ_I : (BIT_REQ_I & CHAN_ACTIVE_I);
   wire logic [3:0] last_idx = 4'(cur_len - 5'd1);
   wire logic code_bit = cur_code[idx_reg];

   // sender fsm
   always_comb begin
      case (state_reg)
         lct_pkg::LCT_ST_IDLE: state_next = send_rq ? lct_pkg::LCT_ST_SEND : lct_pkg::LCT_ST_IDLE;
         lct_pkg::LCT_ST_SEND: state_next = send_rq ? lct_pkg::LCT_ST_SEND : lct_pkg::LCT_ST_IDLE;
         default:              state_next = lct_pkg::LCT_ST_IDLE;
      endcase
   end

   // bit index walks left-most first and wraps so the code repeats without a gap
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= lct_pkg::LCT_ST_IDLE;
         idx_reg   <= 4'h0;
      end else begin
         state_reg <= state_next;
         if (!sending) begin
            idx_reg <= last_idx;
         end else if (strobe) begin
            idx_reg <= (idx_reg == 4'h0) ? last_idx : idx_reg - 4'h1;
         end
      end
   end

   // payload path selection
   wire logic idle_mode = mode_reg == lct_pkg::LCT_TERM || mode_reg == lct_pkg::LCT_DI;
   wire logic idle_bit  = idle_reg[3'd7 - BIT_POS_I];
   wire logic tx_next   = (sending && !is_link && CHAN_ACTIVE_I) ? code_bit :
                          (!CHAN_ACTIVE_I && idle_mode) ? idle_bit : PAY_BIT_I;
   wire logic opp_next  = (mode_reg == lct_pkg::LCT_DI && CHAN_ACTIVE_I) ? idle_bit : OPP_BIT_I;
   wire logic dl_next   = (sending && is_link) ? code_bit : DL_BIT_I;

   // line outputs update one clock after their bit request
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         TX_BIT_O  <= 1'b0;
         OPP_BIT_O <= 1'b0;
         DL_BIT_O  <= 1'b0;
      end else begin
         if (BIT_REQ_I) begin
            TX_BIT_O  <= tx_next;
            OPP_BIT_O <= opp_next;
         end
         if (DL_REQ_I) begin
            DL_BIT_O <= dl_next;
         end
      end
   end

   // auto response; a received code wins over a software clear in the same cycle
   wire logic rx_ok = auto_reg && idle_mode && RX_KIND_I != lct_pkg::LCT_RX_OTHER &&
                      (mode_reg != lct_pkg::LCT_DI || RX_KIND_I == lct_pkg::LCT_RX_V54);
   always_comb begin
      lb_next = lb_reg;
      if (lb_clr || !auto_reg) begin
         lb_next = lct_pkg::LCT_LB_NONE;
      end
      if (rx_ok && RX_DN_I) begin
         lb_next = lct_pkg::LCT_LB_NONE;
      end else if (rx_ok && RX_UP_I) begin
         if (frac_reg || RX_KIND_I == lct_pkg::LCT_RX_V54) begin
            lb_next = lct_pkg::LCT_LB_FRAC;
         end else if (RX_KIND_I == lct_pkg::LCT_RX_PAY) begin
            lb_next = lct_pkg::LCT_LB_PAY;
         end else begin
            lb_next = lct_pkg::LCT_LB_LINE;
         end
      end
   end

   // alarm and status outputs
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         lb_reg      <= lct_pkg::LCT_LB_NONE;
         YELLOW_O    <= 1'b0;
         LINE_IDLE_O <= 1'b0;
      end else begin
         lb_reg      <= lb_next;
         YELLOW_O    <= idle_mode && (yel_reg == lct_pkg::LCT_YEL_ON ||
                        (yel_reg == lct_pkg::LCT_YEL_AUTO && los_reg));
         LINE_IDLE_O <= lidle_reg;
      end
   end

   assign LOOPBACK_O   = lb_reg;
   assign VOICE_EN_O   = voice_reg;
   assign VOICE_CHAN_O = chan_reg;
   assign SIG_ABCD_O   = abcd_reg;
   assign CHAN_FMT_O   = fmt_reg;
   assign REP_ADDR_O   = addr_reg;

   // checks
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!rst_n);

   property p_len;
      cur_len >= `LCT_LEN_MIN && cur_len <= `LCT_LEN_MAX;
   endproperty
   a_len: assert property (p_len) else $error("code length out of range");
   property p_set;
      {28'h0, set_reg} < NSETS;
   endproperty
   a_set: assert property (p_set) else $error("set number out of range");
   property p_v54;
      sending && src_reg == lct_pkg::LCT_SRC_V54 |-> $past(frac_reg) && !$past(dds_alt_reg);
   endproperty
   a_v54: assert property (p_v54) else $error("v54 sent outside fractional");
   property p_di_rx;
      mode_reg == lct_pkg::LCT_DI && RX_UP_I && RX_KIND_I != lct_pkg::LCT_RX_V54 && !lb_clr && auto_reg
         |=> $stable(lb_reg);
   endproperty
   a_di_rx: assert property (p_di_rx) else $error("non v54 code answered in drop insert");
   property p_link;
      DL_REQ_I && sending && is_link |=> DL_BIT_O == $past(code_bit) && $past(esf_reg);
   endproperty
   a_link: assert property (p_link) else $error("link code bit wrong");
   property p_inc;
      inc_cmd && !dec_cmd && !w_addr |=> addr_reg == $past(addr_reg) + 11'h1;
   endproperty
   a_inc: assert property (p_inc) else $error("address increment wrong");
   property p_chan;
      VOICE_CHAN_O >= 5'd1 && VOICE_CHAN_O <= `LCT_CH_MAX;
   endproperty
   a_chan: assert property (p_chan) else $error("voice channel out of range");
   property p_yel;
      mode_reg == lct_pkg::LCT_TERM && yel_reg == lct_pkg::LCT_YEL_ON ##1 $stable(yel_reg) |-> YELLOW_O;
   endproperty
   a_yel: assert property (p_yel) else $error("yellow not sent");
   property p_stop;
      !cmd_up_reg && !cmd_dn_reg |=> !sending;
   endproperty
   a_stop: assert property (p_stop) else $error("code still sent after command end");
   property p_term;
      sending |-> $past(mode_reg) == lct_pkg::LCT_TERM;
   endproperty
   a_term: assert property (p_term) else $error("code sent outside terminate");
   c_send: cover property (sending ##1 strobe && idx_reg == 4'h0);
   c_resp: cover property (rx_ok && RX_UP_I ##1 lb_reg != lct_pkg::LCT_LB_NONE);
   c_link: cover property (sending && is_link && DL_REQ_I);
endmodule
`default_nettype wire

/* sim/lct_span_model.sv */
// far-side span model: pulls line and data-link bits and shifts them in
`timescale 1ns/1ps
`default_nettype none
module lct_span_model (
   input  wire logic        clk_i,
   input  wire logic        en_i,
   input  wire logic        tx_bit_i,
   input  wire logic        dl_bit_i,
   output logic             req_o,
   output logic [2:0]       pos_o,
   output logic [15:0]      line_o,
   output logic [15:0]      link_o,
   output logic [4:0]       cnt_o
);
   logic [1:0] ph  = 2'h0;
   logic       rq  = 1'b0;
   logic       got = 1'b0;
   assign req_o = rq;
   assign pos_o = rq ? cnt_o[2:0] : 3'h0;
   // one request every fourth cycle; the bit is taken one edge after it
   always @(posedge clk_i) begin
      ph  <= ph + 2'h1;
      rq  <= en_i && ph == 2'h0;
      got <= rq;
      if (!en_i) begin
         cnt_o  <= 5'h0;
         line_o <= 16'h0;
         link_o <= 16'h0;
      end else if (got) begin
         cnt_o  <= cnt_o + 5'h1;
         line_o <= {line_o[14:0], tx_bit_i};
         link_o <= {link_o[14:0], dl_bit_i};
      end
   end
endmodule
`default_nettype wire

/* sim/lct_loop_code_tx_tb.sv */
// bench: apb access, code streams and loopback response
`timescale 1ns/1ps
`default_nettype none
module lct_loop_code_tx_tb;
   logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, en = 1'b0;
   logic        los = 1'b0, rup = 1'b0, rdn = 1'b0, act = 1'b1, serr;
   logic [1:0]  kind = 2'h0;
   logic [7:0]  pa = 8'h0;
   logic [31:0] pwd = 32'h0, rd;
   // link pairs, then the default arm, near arm, disarm and v.54 up codes of the instance
   logic [15:0] tab [10] = '{16'hff70, 16'hff1c, 16'hff28, 16'hff4c, 16'h0048, 16'h0024,
                             16'h0003, 16'h0005, 16'h0006, 16'h0001};
   logic [31:0] nos [4] = '{32'h1, 32'h40, 32'h54, 32'h80};
   logic [11:0] rsp [6] = '{12'h206, 12'h201, 12'h24b, 12'h210, 12'h21b, 12'h000};
   wire logic [31:0] prd;
   wire logic        rdy, perr, tx, dl, yel, lidle, req, opp, ven;
   wire logic [1:0]  lb, fmt;
   wire logic [2:0]  pos;
   wire logic [3:0]  abcd;
   wire logic [4:0]  cnt, vch;
   wire logic [10:0] adr;
   wire logic [15:0] lsr, dsr;
   int               err_total = 0, compares = 0;
   always #2 clk = ~clk;
   lct_loop_code_tx u_lct_loop_code_tx (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(perr),
      .BIT_REQ_I(req), .BIT_POS_I(pos), .CHAN_ACTIVE_I(act), .PAY_BIT_I(1'b0), .TX_BIT_O(tx),
      .OPP_BIT_I(1'b0), .OPP_BIT_O(opp), .DL_REQ_I(req), .DL_BIT_I(1'b0), .DL_BIT_O(dl), .LOS_I(los),
      .RX_UP_I(rup), .RX_DN_I(rdn), .RX_KIND_I(kind), .YELLOW_O(yel), .LINE_IDLE_O(lidle), .LOOPBACK_O(lb),
      .VOICE_EN_O(ven), .VOICE_CHAN_O(vch), .SIG_ABCD_O(abcd), .CHAN_FMT_O(fmt), .REP_ADDR_O(adr));
   // link tap also carries the opposite path; each rests at zero while the other is tested
   lct_span_model u_lct_span_model (.clk_i(clk), .en_i(en), .tx_bit_i(tx), .dl_bit_i(dl ^ opp), .req_o(req),
      .pos_o(pos), .line_o(lsr), .link_o(dsr), .cnt_o(cnt));
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      compares++;
      if (got !== ex) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", nm, ex, got);
      end
   endtask
   // idle edge first, so back-to-back calls never drive psel twice in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr  <= w;
      pa   <= a;
      pwd  <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      rd   = prd;
      serr = perr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask
   // start a code, pull 16 bits and compare with the code repeated from its left end
   task automatic send(input logic [31:0] c, input logic [1:0] cm, input bit lk, input int ln, input logic [15:0] cd);
      logic [15:0] ex;
      for (int i = 0; i < 16; i++) ex[15 - i] = cd[ln - 1 - i % ln];
      apb(1'b1, 8'h00, c);
      apb(1'b1, 8'h04, {30'h0, cm});
      en <= 1'b1;
      do @(negedge clk); while (cnt !== 5'd16);
      chk("code", {16'h0, ex}, {16'h0, lk ? dsr : lsr});
      @(posedge clk);
      en <= 1'b0;
      apb(1'b1, 8'h04, 32'h0);
   endtask
   task end_of_test;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // main sequence; a write of the length field outside 3..16 must be dropped
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, 8'h0c, 32'h0);
      chk("chan", 32'h0004e17f, rd);
      apb(1'b0, 8'ha4, 32'h0);
      chk("dn9", 32'h00030004, rd);
      apb(1'b0, 8'h3c, 32'h0);
      chk("unmapped", 32'h1, {31'h0, serr});
      $display("registers done");
      send(32'h0, 2'b01, 1'b0, 5, 16'h0010);
      apb(1'b1, 8'h4c, 32'h0010b00d);
      apb(1'b1, 8'h8c, 32'h00030006);
      apb(1'b1, 8'h4c, 32'h00020001);
      send(32'h0600, 2'b01, 1'b0, 16, 16'hb00d);
      send(32'h0600, 2'b10, 1'b0, 3, 16'h0006);
      for (int k = 0; k < 6; k++) send(32'h8 | (32'(k / 2 + 2) << 6), 2'(k % 2 + 1), 1'b1, 16, tab[k]);
      for (int k = 6; k < 9; k++) send(32'(k - 1) << 6, 2'b01, 1'b0, 16, tab[k]);
      send(32'h44, 2'b01, 1'b0, 16, tab[9]);
      foreach (nos[i]) begin
         apb(1'b1, 8'h00, nos[i]);
         apb(1'b1, 8'h04, 32'h1);
         apb(1'b0, 8'h08, 32'h0);
         chk("sending", 32'h0, {31'h0, rd[0]});
      end
      $display("codes done");
      apb(1'b1, 8'h10, 32'h5);
      apb(1'b1, 8'h04, 32'h4);
      apb(1'b0, 8'h10, 32'h0);
      chk("inc", 32'h6, rd);
      apb(1'b1, 8'h04, 32'h8);
      apb(1'b1, 8'h04, 32'h8);
      apb(1'b0, 8'h10, 32'h0);
      chk("dec", 32'h4, {21'h0, adr});
      apb(1'b1, 8'h00, 32'ha000);
      apb(1'b0, 8'h00, 32'h0);
      chk("yel_on", 32'h3, {30'h0, yel, lidle});
      apb(1'b1, 8'h00, 32'h4000);
      los <= 1'b1;
      repeat (5) @(negedge clk);
      chk("yel_auto", 32'h2, {30'h0, yel, lidle});
      foreach (rsp[i]) begin
         apb(1'b1, 8'h00, {24'h0, rsp[i][11:4]});
         kind <= rsp[i][3:2];
         rup  <= 1'b1;
         @(posedge clk);
         rup <= 1'b0;
         @(negedge clk);
         chk("loopback", {30'h0, rsp[i][1:0]}, {30'h0, lb});
         @(posedge clk);
         rdn <= 1'b1;
         @(posedge clk);
         rdn <= 1'b0;
      end
      $display("response done");
      // c, d and format follow the framing; then the idle byte on the line and opposite paths
      apb(1'b1, 8'h0c, 32'h000318a5);
      apb(1'b0, 8'h0c, 32'h0);
      chk("chan_sf", 32'h000378a5, rd);
      apb(1'b1, 8'h00, 32'h00010008);
      apb(1'b1, 8'h0c, 32'h000018a5);
      act <= 1'b0;
      @(negedge clk);
      chk("voice", 32'he01, {20'h0, ven, vch, abcd, fmt});
      send(32'h10001, 2'b00, 1'b0, 8, 16'h00a5);
      act <= 1'b1;
      send(32'h10001, 2'b00, 1'b1, 8, 16'h00a5);
      $display("idle done");
      end_of_test;
   end
   // watchdog well beyond the expected run
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_of_test;
   end
endmodule
`default_nettype wire
